// >>> rtl/cpu_register_datapath.sv
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "cpu_datapath_cfg.svh"

module cpu_register_datapath (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic mem_req,
	output logic [17:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [17:0] mem_rdata,
	input wire logic [17:0] console_sw,
	output logic io_wr,
	output logic [17:0] io_wdata,
	output logic io_rd,
	input wire logic [17:0] io_rdata
);

	cpu_datapath_pkg::state_e state_ff;
	cpu_datapath_pkg::word_t result_register_ff;
	logic link_ff;
	cpu_datapath_pkg::word_t next_instruction_pointer_ff;
	cpu_datapath_pkg::word_t effective_pointer_ff;
	cpu_datapath_pkg::word_t memory_read_buffer_ff;
	cpu_datapath_pkg::word_t index_register_ff;
	cpu_datapath_pkg::word_t switch_buf_ff;
	logic [5:0] opcode_latch_ff;
	logic twos_mode_ff;
	logic [4:0] last_cmd_ff;
	logic aw_ok_ff, w_ok_ff, ar_ok_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic bvalid_ff, rvalid_ff, awready_ff, wready_ff, arready_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic mem_req_ff;
	cpu_datapath_pkg::word_t mem_addr_ff;
	logic io_wr_ff, io_rd_ff;
	cpu_datapath_pkg::word_t io_wdata_ff;
	logic nxt_aw_ok, nxt_w_ok, nxt_rvalid, nxt_bvalid;
	logic wr_fire, cmd_go, idle, fetch_done, oper_done;
	cpu_datapath_pkg::cmd_e cmd;
	logic [18:0] nxt_link_res;
	cpu_datapath_pkg::word_t wr_word;
	cpu_datapath_pkg::word_t fetch_eff;

	// Byte-lane merge of a bus write into an 18-bit register
	function automatic cpu_datapath_pkg::word_t merge(
		input cpu_datapath_pkg::word_t old_v,
		input logic [31:0] new_v,
		input logic [3:0] strb
	);
		logic [31:0] m;
		m = {14'h0000, old_v};
		for (int b = 0; b < 4; b++) begin
			if (strb[b])
				m[b*8 +: 8] = new_v[b*8 +: 8];
		end
		return m[17:0];
	endfunction : merge

	// Arithmetic unit: returns {link, result}
	function automatic logic [18:0] arith_unit(
		input cpu_datapath_pkg::cmd_e op,
		input cpu_datapath_pkg::word_t ac,
		input logic lk,
		input cpu_datapath_pkg::word_t mw,
		input cpu_datapath_pkg::word_t sw,
		input logic twos
	);
		logic [18:0] sum;
		cpu_datapath_pkg::word_t oc;
		logic ovf;
		sum = {1'b0, ac} + {1'b0, mw};
		oc = sum[17:0] + {17'h00000, sum[18]};
		ovf = (ac[17] == mw[17]) && (oc[17] != ac[17]);
		unique case (op)
			cpu_datapath_pkg::CMD_CLR_RES: return {lk, `RST_WORD};
			cpu_datapath_pkg::CMD_CPL_RES: return {lk, ~ac};
			cpu_datapath_pkg::CMD_ROT_L: return {ac, lk};
			cpu_datapath_pkg::CMD_ROT_R: return {ac[0], lk, ac[17:1]};
			cpu_datapath_pkg::CMD_SHL: return {ac, 1'b0};
			cpu_datapath_pkg::CMD_SHR: return {1'b0, lk, ac[17:1]};
			cpu_datapath_pkg::CMD_ADD: begin
				if (twos)
					return {lk, ac} + {1'b0, mw};
				else
					return {lk | ovf, oc};
			end
			cpu_datapath_pkg::CMD_AND: return {lk, ac & mw};
			cpu_datapath_pkg::CMD_XOR: return {lk, ac ^ mw};
			cpu_datapath_pkg::CMD_OR_SW: return {lk, ac | sw};
			cpu_datapath_pkg::CMD_CLR_LINK: return {1'b0, ac};
			cpu_datapath_pkg::CMD_CPL_LINK: return {~lk, ac};
			default: return {lk, ac};
		endcase
	endfunction : arith_unit

	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign mem_req = mem_req_ff;
	assign mem_addr = mem_addr_ff;
	assign io_wr = io_wr_ff;
	assign io_rd = io_rd_ff;
	assign io_wdata = io_wdata_ff;

	assign idle = (state_ff == cpu_datapath_pkg::ST_IDLE);
	assign wr_fire = aw_ok_ff && w_ok_ff && !bvalid_ff;
	assign cmd_go = wr_fire && idle && (awaddr_ff == `ADDR_CMD);
	assign fetch_done = (state_ff == cpu_datapath_pkg::ST_FETCH) && mem_ack;
	assign oper_done = (state_ff == cpu_datapath_pkg::ST_OPERAND) && mem_ack;
	assign wr_word = wdata_ff[17:0];

	always_comb begin
		cmd = cpu_datapath_pkg::cmd_e'(wdata_ff[4:0]);
		if (!cmd_go)
			cmd = cpu_datapath_pkg::CMD_NOP;
		nxt_link_res = arith_unit(cmd, result_register_ff, link_ff,
			memory_read_buffer_ff, switch_buf_ff, twos_mode_ff);
		// Address field within the current page, or indexed
		if (mem_rdata[`OPL_LSB + `OPL_INDEX_BIT])
			fetch_eff = index_register_ff +
				{6'h00, mem_rdata[`FIELD_MSB:0]};
		else
			fetch_eff = {next_instruction_pointer_ff[`OPL_MSB:`PAGE_LSB],
				mem_rdata[`FIELD_MSB:0]};
		nxt_aw_ok = aw_ok_ff;
		if (s_axi_awvalid && awready_ff)
			nxt_aw_ok = 1'b1;
		else if (wr_fire)
			nxt_aw_ok = 1'b0;
		nxt_w_ok = w_ok_ff;
		if (s_axi_wvalid && wready_ff)
			nxt_w_ok = 1'b1;
		else if (wr_fire)
			nxt_w_ok = 1'b0;
		nxt_bvalid = bvalid_ff;
		if (wr_fire)
			nxt_bvalid = 1'b1;
		else if (s_axi_bready)
			nxt_bvalid = 1'b0;
		nxt_rvalid = rvalid_ff;
		if (ar_ok_ff)
			nxt_rvalid = 1'b1;
		else if (s_axi_rready)
			nxt_rvalid = 1'b0;
	end

	// Write channel handshake; address and data taken in either order
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			aw_ok_ff <= 1'b0;
			w_ok_ff <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `RESP_OKAY;
			awaddr_ff <= 8'h00;
			wdata_ff <= `RST_BUS;
			wstrb_ff <= 4'h0;
		end else begin
			aw_ok_ff <= nxt_aw_ok;
			w_ok_ff <= nxt_w_ok;
			awready_ff <= !nxt_aw_ok;
			wready_ff <= !nxt_w_ok;
			bvalid_ff <= nxt_bvalid;
			if (s_axi_awvalid && awready_ff)
				awaddr_ff <= s_axi_awaddr;
			if (s_axi_wvalid && wready_ff) begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_fire) begin
				unique case (awaddr_ff)
					`ADDR_CMD, `ADDR_CTRL, `ADDR_STATUS, `ADDR_RESULT,
					`ADDR_IPTR, `ADDR_EPTR, `ADDR_OPL, `ADDR_INDEX,
					`ADDR_SWITCH, `ADDR_MRB: bresp_ff <= `RESP_OKAY;
					default: bresp_ff <= `RESP_DECERR;
				endcase
			end
		end
	end

	// Read channel: one read at a time, answer two edges after arvalid
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ar_ok_ff <= 1'b0;
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= `RST_BUS;
			rresp_ff <= `RESP_OKAY;
		end else begin
			ar_ok_ff <= s_axi_arvalid && arready_ff;
			arready_ff <= !nxt_rvalid && !(s_axi_arvalid && arready_ff)
				&& !ar_ok_ff;
			rvalid_ff <= nxt_rvalid;
			if (s_axi_arvalid && arready_ff) begin
				rresp_ff <= `RESP_OKAY;
				rdata_ff <= `RST_BUS;
				unique case (s_axi_araddr)
					`ADDR_CMD: rdata_ff[4:0] <= last_cmd_ff;
					`ADDR_CTRL: rdata_ff[`CTRL_TWOS_BIT] <= twos_mode_ff;
					`ADDR_STATUS: begin
						rdata_ff[`STAT_BUSY_BIT] <= !idle;
						rdata_ff[`STAT_LINK_BIT] <= link_ff;
						rdata_ff[`STAT_INDIR_BIT] <=
							opcode_latch_ff[`OPL_INDIR_BIT];
						rdata_ff[`STAT_INDEX_BIT] <=
							opcode_latch_ff[`OPL_INDEX_BIT];
						rdata_ff[`STAT_CODE_MSB:`STAT_CODE_LSB] <=
							opcode_latch_ff[`OPL_CODE_MSB:`OPL_CODE_LSB];
					end
					`ADDR_RESULT: rdata_ff[17:0] <= result_register_ff;
					`ADDR_IPTR: rdata_ff[17:0] <= next_instruction_pointer_ff;
					`ADDR_EPTR: rdata_ff[17:0] <= effective_pointer_ff;
					`ADDR_OPL: rdata_ff[5:0] <= opcode_latch_ff;
					`ADDR_INDEX: rdata_ff[17:0] <= index_register_ff;
					`ADDR_SWITCH: rdata_ff[17:0] <= switch_buf_ff;
					`ADDR_MRB: rdata_ff[17:0] <= memory_read_buffer_ff;
					default: rresp_ff <= `RESP_DECERR;
				endcase
			end
		end
	end

	// Console switch word is re-buffered every clock
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			switch_buf_ff <= `RST_WORD;
		else
			switch_buf_ff <= console_sw;
	end

	// Software settings; datapath registers only take writes while idle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			twos_mode_ff <= 1'b0;
			last_cmd_ff <= 5'h00;
			index_register_ff <= `RST_WORD;
		end else if (wr_fire) begin
			if (awaddr_ff == `ADDR_CTRL && wstrb_ff[0])
				twos_mode_ff <= wdata_ff[`CTRL_TWOS_BIT];
			if (cmd_go)
				last_cmd_ff <= wdata_ff[4:0];
			if (awaddr_ff == `ADDR_INDEX && idle)
				index_register_ff <= merge(index_register_ff, wdata_ff,
					wstrb_ff);
		end
	end

	// Result register and link
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			result_register_ff <= `RST_WORD;
			link_ff <= 1'b0;
		end else if (cmd_go && cmd == cpu_datapath_pkg::CMD_IO_IN) begin
			result_register_ff <= io_rdata;
		end else if (wr_fire && idle && awaddr_ff == `ADDR_RESULT) begin
			result_register_ff <= merge(result_register_ff, wdata_ff,
				wstrb_ff);
		end else begin
			// Holds its value whenever no operation is issued
			{link_ff, result_register_ff} <= nxt_link_res;
		end
	end

	// Programmed I/O strobes
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			io_wr_ff <= 1'b0;
			io_rd_ff <= 1'b0;
			io_wdata_ff <= `RST_WORD;
		end else begin
			io_wr_ff <= cmd_go && cmd == cpu_datapath_pkg::CMD_IO_OUT;
			io_rd_ff <= cmd_go && cmd == cpu_datapath_pkg::CMD_IO_IN;
			if (cmd_go && cmd == cpu_datapath_pkg::CMD_IO_OUT)
				io_wdata_ff <= result_register_ff;
		end
	end

	// Memory access sequencer
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_ff <= cpu_datapath_pkg::ST_IDLE;
			mem_req_ff <= 1'b0;
			mem_addr_ff <= `RST_WORD;
		end else begin
			unique case (state_ff)
				cpu_datapath_pkg::ST_IDLE: begin
					if (cmd == cpu_datapath_pkg::CMD_FETCH) begin
						state_ff <= cpu_datapath_pkg::ST_FETCH;
						mem_req_ff <= 1'b1;
						// Low 15 bits reach core, top 3 extend it
						mem_addr_ff <=
							next_instruction_pointer_ff;
					end else if (cmd == cpu_datapath_pkg::CMD_OPERAND) begin
						state_ff <= cpu_datapath_pkg::ST_OPERAND;
						mem_req_ff <= 1'b1;
						mem_addr_ff <= effective_pointer_ff;
					end
				end
				cpu_datapath_pkg::ST_FETCH, cpu_datapath_pkg::ST_OPERAND: begin
					if (mem_ack) begin
						state_ff <= cpu_datapath_pkg::ST_IDLE;
						mem_req_ff <= 1'b0;
					end
				end
				default: begin
					state_ff <= cpu_datapath_pkg::ST_IDLE;
					mem_req_ff <= 1'b0;
				end
			endcase
		end
	end

	// Read buffer, opcode latch and pointers
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			memory_read_buffer_ff <= `RST_WORD;
			opcode_latch_ff <= `RST_OPL;
			next_instruction_pointer_ff <= `RST_WORD;
			effective_pointer_ff <= `RST_WORD;
		end else begin
			if (fetch_done || oper_done)
				memory_read_buffer_ff <= mem_rdata;
			if (fetch_done) begin
				opcode_latch_ff <= mem_rdata[`OPL_MSB:`OPL_LSB];
				effective_pointer_ff <= fetch_eff;
				next_instruction_pointer_ff <= next_instruction_pointer_ff
					+ `ONE_WORD;
			end else if (cmd == cpu_datapath_pkg::CMD_JUMP) begin
				next_instruction_pointer_ff <= effective_pointer_ff;
			end else if (wr_fire && idle && awaddr_ff == `ADDR_IPTR) begin
				next_instruction_pointer_ff <= merge(
					next_instruction_pointer_ff, wdata_ff, wstrb_ff);
			end
		end
	end

	sequence s_fetch_done;
		state_ff == cpu_datapath_pkg::ST_FETCH && mem_ack;
	endsequence

	sequence s_go(cpu_datapath_pkg::cmd_e c);
		cmd_go && cmd == c;
	endsequence

	property p_opcode_top_bits;
		@(posedge core_clk) disable iff (!rst_n)
		s_fetch_done |=> opcode_latch_ff ==
			$past(mem_rdata[`OPL_MSB:`OPL_LSB])
			&& memory_read_buffer_ff == $past(mem_rdata);
	endproperty
	a_opcode_top_bits: assert property (p_opcode_top_bits)
		else $error("opcode latch not loaded from fetched word");

	property p_ip_advance;
		@(posedge core_clk) disable iff (!rst_n)
		s_fetch_done |=> next_instruction_pointer_ff ==
			$past(next_instruction_pointer_ff) + `ONE_WORD;
	endproperty
	a_ip_advance: assert property (p_ip_advance)
		else $error("instruction pointer did not advance by one");

	property p_indexed_eff;
		@(posedge core_clk) disable iff (!rst_n)
		s_fetch_done ##0 mem_rdata[12] |=> effective_pointer_ff ==
			$past(index_register_ff) + {6'h00, $past(mem_rdata[11:0])};
	endproperty
	a_indexed_eff: assert property (p_indexed_eff)
		else $error("indexed effective address wrong");

	property p_clear_result;
		@(posedge core_clk) disable iff (!rst_n)
		s_go(cpu_datapath_pkg::CMD_CLR_RES) |=> result_register_ff == 18'h0
			##1 result_register_ff == 18'h0 || !$stable(last_cmd_ff)
			|| $past(wr_fire);
	endproperty
	a_clear_result: assert property (p_clear_result)
		else $error("result register not cleared");

	property p_link_alone;
		@(posedge core_clk) disable iff (!rst_n)
		s_go(cpu_datapath_pkg::CMD_CPL_LINK) |=> link_ff == !$past(link_ff)
			&& $stable(result_register_ff);
	endproperty
	a_link_alone: assert property (p_link_alone)
		else $error("link complement disturbed result");

	property p_rotate_left;
		@(posedge core_clk) disable iff (!rst_n)
		s_go(cpu_datapath_pkg::CMD_ROT_L) |=> {link_ff, result_register_ff}
			== {$past(result_register_ff), $past(link_ff)};
	endproperty
	a_rotate_left: assert property (p_rotate_left)
		else $error("19-bit rotate left wrong");

	property p_twos_add;
		@(posedge core_clk) disable iff (!rst_n)
		s_go(cpu_datapath_pkg::CMD_ADD) ##0 twos_mode_ff |=>
			{link_ff, result_register_ff} == $past({link_ff,
			result_register_ff}) + {1'b0, $past(memory_read_buffer_ff)};
	endproperty
	a_twos_add: assert property (p_twos_add)
		else $error("two's complement add wrong");

	property p_switch_buffer;
		@(posedge core_clk) disable iff (!rst_n)
		rst_n |=> switch_buf_ff == $past(console_sw);
	endproperty
	a_switch_buffer: assert property (p_switch_buffer)
		else $error("switch buffer does not follow console");

	property p_io_out;
		@(posedge core_clk) disable iff (!rst_n)
		s_go(cpu_datapath_pkg::CMD_IO_OUT) |=> io_wr_ff
			&& io_wdata_ff == $past(result_register_ff) ##1 !io_wr_ff;
	endproperty
	a_io_out: assert property (p_io_out)
		else $error("output word not taken from result register");

endmodule : cpu_register_datapath

// >>> rtl/cpu_datapath_cfg.svh
`ifndef CPU_DATAPATH_CFG_SVH
`define CPU_DATAPATH_CFG_SVH

// Word and field layout
`define WORD_W 18
`define OPL_W 6
`define OPL_MSB 17
`define OPL_LSB 12
`define FIELD_MSB 11
`define PAGE_LSB 12
`define CORE_ADDR_W 15
`define EXT_W 3
`define OPL_CODE_MSB 5
`define OPL_CODE_LSB 2
`define OPL_INDIR_BIT 1
`define OPL_INDEX_BIT 0

// Register byte offsets
`define ADDR_CMD 8'h00
`define ADDR_CTRL 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_RESULT 8'h0c
`define ADDR_IPTR 8'h10
`define ADDR_EPTR 8'h14
`define ADDR_OPL 8'h18
`define ADDR_INDEX 8'h1c
`define ADDR_SWITCH 8'h20
`define ADDR_MRB 8'h24

// Field positions
`define CMD_W 5
`define CTRL_TWOS_BIT 0
`define STAT_BUSY_BIT 0
`define STAT_LINK_BIT 1
`define STAT_INDIR_BIT 2
`define STAT_INDEX_BIT 3
`define STAT_CODE_LSB 4
`define STAT_CODE_MSB 7

// Reset values and bus answers
`define RST_WORD 18'h00000
`define RST_OPL 6'h00
`define RST_BUS 32'h00000000
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`define ONE_WORD 18'h00001

`endif

// >>> rtl/cpu_datapath_pkg.sv
package cpu_datapath_pkg;

	typedef enum logic [4:0] {
		CMD_NOP = 5'h00,
		CMD_CLR_RES = 5'h01,
		CMD_CPL_RES = 5'h02,
		CMD_ROT_L = 5'h03,
		CMD_ROT_R = 5'h04,
		CMD_SHL = 5'h05,
		CMD_SHR = 5'h06,
		CMD_ADD = 5'h07,
		CMD_AND = 5'h08,
		CMD_XOR = 5'h09,
		CMD_OR_SW = 5'h0a,
		CMD_CLR_LINK = 5'h0b,
		CMD_CPL_LINK = 5'h0c,
		CMD_FETCH = 5'h0d,
		CMD_OPERAND = 5'h0e,
		CMD_JUMP = 5'h0f,
		CMD_IO_OUT = 5'h10,
		CMD_IO_IN = 5'h11
	} cmd_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_FETCH = 3'b010,
		ST_OPERAND = 3'b100
	} state_e;

	typedef logic [17:0] word_t;

endpackage : cpu_datapath_pkg

// >>> tb/mem_io_model.sv
`timescale 1ns/1ps
module mem_io_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic mem_req,
	input wire logic [17:0] mem_addr,
	output logic mem_ack,
	output logic [17:0] mem_rdata,
	input wire logic io_wr,
	input wire logic [17:0] io_wdata,
	input wire logic io_rd,
	output logic [17:0] io_rdata,
	input wire logic [7:0] delay
);
	// One bank of two 4096-word pages; higher addresses wrap onto it
	logic [17:0] mem [0:8191];
	logic [17:0] last_addr;
	logic [17:0] io_seen;
	logic [17:0] io_word = 18'h00000;
	int wait_n;
	int io_count = 0;
	int rd_count = 0;

	assign io_rdata = io_word;

	always @(posedge core_clk) begin
		if (!rst_n) begin
			mem_ack <= 1'b0;
			mem_rdata <= 18'h15555;
			wait_n <= 0;
		end else if (mem_req && !mem_ack && wait_n >= delay) begin
			mem_ack <= 1'b1;
			mem_rdata <= mem[mem_addr[12:0]];
			last_addr <= mem_addr;
			wait_n <= 0;
		end else begin
			// Data lines carry no valid word outside the acknowledge cycle
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			wait_n <= (mem_req && !mem_ack) ? wait_n + 1 : 0;
		end
	end

	always @(posedge core_clk) begin
		if (io_wr === 1'b1) begin
			io_seen <= io_wdata;
			io_count <= io_count + 1;
		end
		if (io_rd === 1'b1) begin
			rd_count <= rd_count + 1;
		end
	end
endmodule : mem_io_model

// >>> tb/testbench.sv
`timescale 1ns/1ps
`include "cpu_datapath_cfg.svh"
module testbench;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, last_b, last_r;
	logic [31:0] rdata, rd_v;
	logic mem_req, mem_ack, io_wr, io_rd;
	logic [17:0] mem_addr, mem_rdata, io_wdata, io_rdata;
	logic [17:0] console_sw = 18'h00f0f;
	logic [7:0] delay = 8'h02;
	int err_total = 0;
	int num_checks = 0;
	// Rows: {mode, link before}, command, result before, result, link
	logic [1:0] t_ml [14] = '{2'h2, 2'h3, 2'h3, 2'h2, 2'h2, 2'h3, 2'h2,
		2'h0, 2'h0, 2'h2, 2'h3, 2'h2, 2'h2, 2'h1};
	logic [4:0] t_op [14] = '{5'h02, 5'h01, 5'h03, 5'h04, 5'h05, 5'h06,
		5'h07, 5'h07, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0c, 5'h0b};
	logic [17:0] t_a [14] = '{18'h12345, 18'h12345, 18'h20001, 18'h00003,
		18'h20001, 18'h00002, 18'h3ffff, 18'h0cbba, 18'h00001, 18'h3ffff,
		18'h3ffff, 18'h20000, 18'h12345, 18'h12345};
	logic [17:0] t_r [14] = '{18'h2dcba, 18'h00000, 18'h00003, 18'h00001,
		18'h00002, 18'h20001, 18'h1a344, 18'h26eff, 18'h1a346, 18'h1a345,
		18'h25cba, 18'h20f0f, 18'h12345, 18'h12345};
	logic t_l [14] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1,
		1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
	logic [17:0] fw [2] = '{18'h25007, 18'h1a345};
	logic [17:0] ep [2] = '{18'h00017, 18'h28345};

	always #25 core_clk = ~core_clk;

	cpu_register_datapath dut (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid),
		.s_axi_awready(awready),
		.s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid),
		.s_axi_wready(wready),
		.s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid),
		.s_axi_bready(bready),
		.s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid),
		.s_axi_arready(arready),
		.s_axi_rdata(rdata),
		.s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid),
		.s_axi_rready(rready),
		.mem_req(mem_req),
		.mem_addr(mem_addr),
		.mem_ack(mem_ack),
		.mem_rdata(mem_rdata),
		.console_sw(console_sw),
		.io_wr(io_wr),
		.io_wdata(io_wdata),
		.io_rd(io_rd),
		.io_rdata(io_rdata)
	);

	mem_io_model mdl (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.mem_req(mem_req),
		.mem_addr(mem_addr),
		.mem_ack(mem_ack),
		.mem_rdata(mem_rdata),
		.io_wr(io_wr),
		.io_wdata(io_wdata),
		.io_rd(io_rd),
		.io_rdata(io_rdata),
		.delay(delay)
	);

	task complete_run;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask : check

	task timeout(input int n);
		if (n > 400) begin
			err_total++;
			$display("unexpected at %0t: bus gave no answer", $time);
			complete_run();
		end
	endtask : timeout

	task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		logic aw_d, w_d;
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw_d = 1'b0;
		w_d = 1'b0;
		for (n = 1; n < 1000; n++) begin
			@(posedge core_clk);
			timeout(n);
			if (aw_d && w_d && bvalid === 1'b1) begin
				last_b = bresp;
				bready <= 1'b0;
				break;
			end
			if (!aw_d && awready === 1'b1) begin
				aw_d = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_d && wready === 1'b1) begin
				w_d = 1'b1;
				wvalid <= 1'b0;
			end
		end
	endtask : wr

	task rd(input logic [7:0] a);
		int n;
		logic ar_d;
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		ar_d = 1'b0;
		for (n = 1; n < 1000; n++) begin
			@(posedge core_clk);
			timeout(n);
			if (ar_d && rvalid === 1'b1) begin
				rd_v = rdata;
				last_r = rresp;
				rready <= 1'b0;
				break;
			end
			if (!ar_d && arready === 1'b1) begin
				ar_d = 1'b1;
				arvalid <= 1'b0;
			end
		end
	endtask : rd

	task cmd(input logic [4:0] c);
		wr(`ADDR_CMD, {27'h0000000, c}, 4'hf);
	endtask : cmd

	task wait_idle;
		int n;
		for (n = 0; n < 60; n++) begin
			rd(`ADDR_STATUS);
			if (rd_v[`STAT_BUSY_BIT] === 1'b0)
				break;
		end
		if (n == 60)
			timeout(1000);
	endtask : wait_idle

	initial begin
		mdl.mem[13'h0100] = fw[0];
		mdl.mem[13'h0101] = fw[1];
		mdl.mem[13'h0345] = 18'h0abcd;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(`ADDR_RESULT);
		check(rd_v, 32'h00000000);
		rd(`ADDR_STATUS);
		check(rd_v, 32'h00000000);
		rd(8'h30);
		check({30'h0, last_r}, {30'h0, `RESP_DECERR});
		wr(8'h30, 32'h00000001, 4'hf);
		check({30'h0, last_b}, {30'h0, `RESP_DECERR});
		wr(`ADDR_RESULT, 32'hffffffff, 4'hf);
		wr(`ADDR_RESULT, 32'h00000055, 4'h1);
		rd(`ADDR_RESULT);
		check(rd_v, 32'h0003ff55);
		rd(`ADDR_SWITCH);
		check(rd_v, 32'h00000f0f);
		wr(`ADDR_IPTR, 32'h00028100, 4'hf);
		wr(`ADDR_INDEX, 32'h00000010, 4'hf);
		for (int i = 0; i < 2; i++) begin
			if (i == 1)
				delay <= 8'h14;
			cmd(cpu_datapath_pkg::CMD_FETCH);
			if (i == 1) begin
				wr(`ADDR_RESULT, 32'h00000001, 4'hf);
				rd(`ADDR_STATUS);
				check({31'h0, rd_v[`STAT_BUSY_BIT]}, 32'h00000001);
			end
			wait_idle();
			check({14'h0, mdl.last_addr},
				32'h00028100 + i);
			rd(`ADDR_MRB);
			check(rd_v, {14'h0, fw[i]});
			rd(`ADDR_OPL);
			check(rd_v, {26'h0, fw[i][17:12]});
			rd(`ADDR_STATUS);
			check({26'h0, rd_v[7:4], rd_v[2], rd_v[3]},
				{26'h0, fw[i][17:12]});
			rd(`ADDR_EPTR);
			check(rd_v, {14'h0, ep[i]});
			rd(`ADDR_IPTR);
			check(rd_v, 32'h00028101 + i);
		end
		rd(`ADDR_RESULT);
		check(rd_v, 32'h0003ff55);
		for (int i = 0; i < 14; i++) begin
			wr(`ADDR_CTRL, {31'h0, t_ml[i][1]}, 4'h1);
			cmd(cpu_datapath_pkg::CMD_CLR_LINK);
			if (t_ml[i][0])
				cmd(cpu_datapath_pkg::CMD_CPL_LINK);
			wr(`ADDR_RESULT, {14'h0, t_a[i]}, 4'hf);
			cmd(t_op[i]);
			rd(`ADDR_RESULT);
			check(rd_v, {14'h0, t_r[i]});
			rd(`ADDR_STATUS);
			check({31'h0, rd_v[`STAT_LINK_BIT]},
				{31'h0, t_l[i]});
		end
		cmd(cpu_datapath_pkg::CMD_JUMP);
		rd(`ADDR_IPTR);
		check(rd_v, 32'h00028345);
		cmd(cpu_datapath_pkg::CMD_OPERAND);
		wait_idle();
		check({14'h0, mdl.last_addr}, 32'h00028345);
		rd(`ADDR_MRB);
		check(rd_v, 32'h0000abcd);
		wr(`ADDR_RESULT, 32'h0002abcd, 4'hf);
		cmd(cpu_datapath_pkg::CMD_IO_OUT);
		mdl.io_word <= 18'h15432;
		cmd(cpu_datapath_pkg::CMD_IO_IN);
		rd(`ADDR_RESULT);
		check(rd_v, 32'h00015432);
		check({14'h0, mdl.io_seen}, 32'h0002abcd);
		check(mdl.io_count, 32'h00000001);
		check(mdl.rd_count, 32'h00000001);
		rd(`ADDR_CMD);
		check(rd_v, {27'h0, cpu_datapath_pkg::CMD_IO_IN});
		console_sw <= 18'h2a5a5;
		rd(`ADDR_SWITCH);
		check(rd_v, 32'h0002a5a5);
		complete_run();
	end
endmodule : testbench
